// ==== hw/ppc_pin_ctrl.v ====
// Parallel port pin control: control register over AXI4-Lite and pin shaping
//
// Function
// - Byte-enable pin undriven when its enable clear
// - Bit 9 enables the write/enable strobe pin
// - Bit 8 enables the read strobe pin
// - Chip-select function 10 makes pin 1 select
// - Bit 5 sets both address latch polarities
// - Bit 3 sets chip-select 1 polarity
// - Bit 4 reads zero, writes ignored
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "ppc_consts.vh"
module ppc_pin_ctrl #(
    parameter ADDR_W = 4
) (
    input  wire              clk,
    input  wire              rst_b,
    // AXI4-Lite write address channel
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]        s_axi_awprot,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    // AXI4-Lite write data channel
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    // AXI4-Lite write response channel
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // AXI4-Lite read address channel
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]        s_axi_arprot,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    // AXI4-Lite read data channel
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Active-high strobe requests from the transfer engine, same clock
    input  wire              byte_enable_req,
    input  wire              write_strobe_req,
    input  wire              read_strobe_req,
    input  wire              chip_select1_req,
    input  wire              addr_latch_low_req,
    input  wire              addr_latch_high_req,
    input  wire              addr_latch_used,
    // Pin outputs with output enables
    output reg               byte_enable_pin,
    output reg               byte_enable_pin_oe,
    output reg               write_strobe_pin,
    output reg               write_strobe_pin_oe,
    output reg               read_strobe_pin,
    output reg               read_strobe_pin_oe,
    output reg               chip_select1_pin,
    output reg               chip_select1_pin_oe,
    output reg               addr_latch_low_strobe,
    output reg               addr_latch_high_strobe,
    output reg               addr_latch_oe
);

    wire              rst_sync_b;    // Synchronised reset for all logic
    reg  [15:0]       ctrl;          // Control register
    reg  [ADDR_W-1:0] aw_addr;       // Captured write address
    reg               aw_hold;       // Write address captured
    reg  [31:0]       w_data;        // Captured write data
    reg  [3:0]        w_strb;        // Captured byte strobes
    reg               w_hold;        // Write data captured
    reg  [15:0]       status;        // Live pin state as software sees it
    reg  [15:0]       byte_mask;     // Bits selected by the write strobes
    reg  [15:0]       rd_word;       // Read mux result
    reg               rd_hit;        // Read address is mapped

    // Decoded control fields
    wire       byte_enable_pin_en    = ctrl[`PPC_BIT_BE_EN];
    wire       write_strobe_pin_en   = ctrl[`PPC_BIT_WR_EN];
    wire       read_strobe_pin_en    = ctrl[`PPC_BIT_RD_EN];
    wire [1:0] chip_select_function  = ctrl[`PPC_BIT_CSF_HI:`PPC_BIT_CSF_LO];
    wire       addr_latch_polarity   = ctrl[`PPC_BIT_ALP];
    wire       chip_select1_polarity = ctrl[`PPC_BIT_CHIP_SELECT1_POLARITY];
    wire       cs1_is_select         = (chip_select_function == `PPC_CSF_CHIP_SEL);

    // Offsets at the bus address width, so word indices compare width for width
    localparam [ADDR_W-1:0] ctrl_ofs = `PPC_OFS_CTRL;
    localparam [ADDR_W-1:0] stat_ofs = `PPC_OFS_STATUS;

    // Address decode of the captured write and of the read request
    wire wr_is_ctrl = (aw_addr[ADDR_W-1:2] == ctrl_ofs[ADDR_W-1:2]);
    wire wr_is_stat = (aw_addr[ADDR_W-1:2] == stat_ofs[ADDR_W-1:2]);

    // Reset release through two flip-flops
    ppc_rst_sync u_rst_sync (
        .clk        (clk),
        .rst_b      (rst_b),
        .rst_sync_b (rst_sync_b)
    );

    // Byte lanes 0 and 1 cover the 16-bit control register
    always @* begin
        byte_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    end

    // Status word: pin enables and levels, low byte enables, high byte levels
    always @* begin
        status = {10'h000,
                  byte_enable_pin_oe, write_strobe_pin_oe, read_strobe_pin_oe,
                  chip_select1_pin_oe, addr_latch_oe, 1'b0};
        status[0] = 1'b0;
        status[15:8] = {2'h0, byte_enable_pin, write_strobe_pin, read_strobe_pin,
                        chip_select1_pin, addr_latch_low_strobe, addr_latch_high_strobe};
        status[7:0]  = {2'h0, byte_enable_pin_oe, write_strobe_pin_oe, read_strobe_pin_oe,
                        chip_select1_pin_oe, addr_latch_oe, 1'b0};
    end

    // Read mux; unimplemented control bits are never stored so read zero
    always @* begin
        rd_word = 16'h0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr[ADDR_W-1:2])
            ctrl_ofs[ADDR_W-1:2]: begin
                rd_word = ctrl & `PPC_CTRL_WMASK;
            end
            stat_ofs[ADDR_W-1:2]: begin
                rd_word = status;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Write path: address and data taken in either order, then one response
    always @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PPC_RESP_OKAY;
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= {ADDR_W{1'b0}};
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            ctrl          <= `PPC_CTRL_RESET;
        end else begin
            // Capture address; ready stays low until the response is taken
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                aw_hold       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            // Capture data the same way
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_hold       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // Both halves present: commit and answer
            if (aw_hold && w_hold) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_is_ctrl) begin
                    // Bit 4 and out-of-window bits are masked off here
                    ctrl <= (ctrl & ~byte_mask)
                          | (w_data[15:0] & byte_mask & `PPC_CTRL_WMASK);
                    s_axi_bresp <= `PPC_RESP_OKAY;
                end else if (wr_is_stat) begin
                    // Status is read-only; write accepted and dropped
                    s_axi_bresp <= `PPC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `PPC_RESP_DECERR;
                end
            end
            // Response taken: reopen both channels
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read path: one outstanding read, data registered
    always @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PPC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {16'h0000, rd_word};
                s_axi_rresp   <= rd_hit ? `PPC_RESP_OKAY : `PPC_RESP_DECERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Pin shaping: enables gate the drivers, a clear polarity bit inverts the level
    // A disabled pin is released and its level parked low so nothing glitches
    always @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            byte_enable_pin        <= 1'b0;
            byte_enable_pin_oe     <= 1'b0;
            write_strobe_pin       <= 1'b0;
            write_strobe_pin_oe    <= 1'b0;
            read_strobe_pin        <= 1'b0;
            read_strobe_pin_oe     <= 1'b0;
            chip_select1_pin       <= 1'b0;
            chip_select1_pin_oe    <= 1'b0;
            addr_latch_low_strobe  <= 1'b0;
            addr_latch_high_strobe <= 1'b0;
            addr_latch_oe          <= 1'b0;
        end else begin
            // Byte enable only as port function when enabled
            byte_enable_pin_oe  <= byte_enable_pin_en;
            byte_enable_pin     <= byte_enable_pin_en & byte_enable_req;
            // Write or enable strobe
            write_strobe_pin_oe <= write_strobe_pin_en;
            write_strobe_pin    <= write_strobe_pin_en & write_strobe_req;
            // Read or read/write strobe
            read_strobe_pin_oe  <= read_strobe_pin_en;
            read_strobe_pin     <= read_strobe_pin_en & read_strobe_req;
            // Chip select only in the select code; reserved codes release it
            chip_select1_pin_oe <= cs1_is_select;
            if (cs1_is_select) begin
                chip_select1_pin <= chip_select1_req ^ ~chip_select1_polarity;
            end else begin
                chip_select1_pin <= 1'b0;
            end
            // Both latch strobes share one polarity bit
            addr_latch_oe <= addr_latch_used;
            if (addr_latch_used) begin
                addr_latch_low_strobe  <= addr_latch_low_req ^ ~addr_latch_polarity;
                addr_latch_high_strobe <= addr_latch_high_req ^ ~addr_latch_polarity;
            end else begin
                addr_latch_low_strobe  <= 1'b0;
                addr_latch_high_strobe <= 1'b0;
            end
        end
    end

endmodule

// ==== hw/ppc_consts.vh ====
// Constants for the parallel port pin control block
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus
`define PPC_OFS_CTRL        4'h0
`define PPC_OFS_STATUS      4'h4

// Control register field positions
`define PPC_BIT_BE_EN       10
`define PPC_BIT_WR_EN       9
`define PPC_BIT_RD_EN       8
`define PPC_BIT_CSF_HI      7
`define PPC_BIT_CSF_LO      6
`define PPC_BIT_ALP         5
`define PPC_BIT_UNIMP       4
`define PPC_BIT_CHIP_SELECT1_POLARITY        3

// Chip-select function code that makes pin 1 a chip select
`define PPC_CSF_CHIP_SEL    2'h2

// Control register reset value and writable-bit mask
`define PPC_CTRL_RESET      16'h0000
`define PPC_CTRL_WMASK      16'h07E8

// AXI response codes
`define PPC_RESP_OKAY       2'h0
`define PPC_RESP_DECERR     2'h3

`endif

// ==== hw/ppc_rst_sync.v ====
// Reset release synchroniser for the parallel port pin control block
`timescale 1ns/100ps
module ppc_rst_sync (
    input  wire clk,
    input  wire rst_b,
    output reg  rst_sync_b
);

    reg meta_b;     // First stage, read only by the second

    // Assert at once, release after two edges to avoid a ragged release
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_b     <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            meta_b     <= 1'b1;
            rst_sync_b <= meta_b;
        end
    end

endmodule

// ==== tb/ppc_pin_ctrl_props.sv ====
// Checker for the pin control block ports
`timescale 1ns/100ps
`include "ppc_consts.vh"
module ppc_props #(
    parameter ADDR_W = 4
) (
    input wire              clk,
    input wire              rst_b,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire              s_axi_arvalid,
    input wire              s_axi_arready,
    input wire              s_axi_rvalid,
    input wire [31:0]       s_axi_rdata,
    input wire              s_axi_bvalid,
    input wire              byte_enable_req,
    input wire              write_strobe_req,
    input wire              read_strobe_req,
    input wire              chip_select1_req,
    input wire              addr_latch_low_req,
    input wire              addr_latch_high_req,
    input wire              byte_enable_pin,
    input wire              byte_enable_pin_oe,
    input wire              write_strobe_pin,
    input wire              write_strobe_pin_oe,
    input wire              read_strobe_pin,
    input wire              read_strobe_pin_oe,
    input wire              chip_select1_pin,
    input wire              chip_select1_pin_oe,
    input wire              addr_latch_low_strobe,
    input wire              addr_latch_high_strobe,
    input wire              addr_latch_oe
);
    reg rd_ctrl; // Read in flight targets the control register
    // Remember which register the pending read addresses
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            rd_ctrl <= 1'h0;
        else if (s_axi_arvalid && s_axi_arready)
            rd_ctrl <= (s_axi_araddr == `PPC_OFS_CTRL);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_be_gated: assert property (
        byte_enable_pin == (byte_enable_pin_oe & $past(byte_enable_req))) else $error("be pin");
    chk_wr_gated: assert property (
        write_strobe_pin == (write_strobe_pin_oe & $past(write_strobe_req))) else $error("wr pin");
    chk_wr_oe_steady: assert property (
        $changed(write_strobe_pin_oe) |-> $past(s_axi_bvalid)) else $error("wr oe moved");
    chk_rd_gated: assert property (
        read_strobe_pin == (read_strobe_pin_oe & $past(read_strobe_req))) else $error("rd pin");
    chk_cs_idle_low: assert property (
        !chip_select1_pin_oe |-> !chip_select1_pin) else $error("cs pin high while released");
    chk_cs_follows: assert property (
        chip_select1_pin_oe && $past(chip_select1_pin_oe) && !$past(s_axi_bvalid)
        && $past(chip_select1_req) != $past(chip_select1_req, 2)
        |-> chip_select1_pin != $past(chip_select1_pin)) else $error("cs pin did not follow");
    chk_al_same_pol: assert property (
        addr_latch_oe |-> (addr_latch_low_strobe ^ $past(addr_latch_low_req))
        == (addr_latch_high_strobe ^ $past(addr_latch_high_req))) else $error("al polarity");
    chk_bit4_zero: assert property (
        s_axi_rvalid && rd_ctrl |-> !s_axi_rdata[4]) else $error("ctrl bit 4 read one");
    cov_ctrl_read: cover property (s_axi_rvalid && rd_ctrl);
    cov_cs_high: cover property (chip_select1_pin_oe && chip_select1_pin);
    cov_al_high: cover property (addr_latch_oe && addr_latch_low_strobe);
endmodule
bind ppc_pin_ctrl ppc_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ==== tb/ppc_periph.sv ====
// Peripheral model counting write strobe assertions
`timescale 1ns/100ps
module ppc_periph (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       write_strobe_pin,
    input  wire       write_strobe_pin_oe,
    output reg  [7:0] strobe_count
);
    reg last_level; // Level at the previous edge, 0 while released
    // A released line counts as inactive, so floating levels never add strobes
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_count <= 8'h00;
            last_level   <= 1'h0;
        end else begin
            if (write_strobe_pin_oe && write_strobe_pin && !last_level)
                strobe_count <= strobe_count + 8'h01;
            last_level <= write_strobe_pin_oe & write_strobe_pin;
        end
    end
endmodule

// ==== tb/tb.sv ====
// Testbench for the pin control block
`timescale 1ns/100ps
`include "ppc_consts.vh"
module tb;
    reg         clk = 1'h0, rst_b = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    reg         s_axi_arvalid = 1'h0, addr_latch_used = 1'h0, r, u, cso;
    reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    reg  [31:0] s_axi_wdata = 32'h0, data;
    reg         byte_enable_req = 1'h0, write_strobe_req = 1'h0, read_strobe_req = 1'h0;
    reg         chip_select1_req = 1'h0, addr_latch_low_req = 1'h0, addr_latch_high_req = 1'h0;
    wire [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0; // Protection is ignored
    reg  [3:0]  s_axi_wstrb = 4'hF; // Narrowed once for the byte lane test
    wire        s_axi_bready = 1'h1, s_axi_rready = 1'h1; // Always ready for answers
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        byte_enable_pin, byte_enable_pin_oe, write_strobe_pin, write_strobe_pin_oe;
    wire        read_strobe_pin, read_strobe_pin_oe, chip_select1_pin, chip_select1_pin_oe;
    wire        addr_latch_low_strobe, addr_latch_high_strobe, addr_latch_oe;
    wire [7:0]  strobe_count;
    integer     bad_count = 0, tests_run = 0, i, j;
    reg  [1:0]  resp;
    reg  [15:0] c;
    reg  [15:0] cfg [0:4];
    ppc_pin_ctrl #(.ADDR_W(4)) u_dut (.*);
    ppc_periph u_periph (.clk(clk), .rst_b(rst_b), .write_strobe_pin(write_strobe_pin),
        .write_strobe_pin_oe(write_strobe_pin_oe), .strobe_count(strobe_count));
    initial forever #25 clk = ~clk;
    // Compare and count
    task chk(input [8*8:1] nm, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
                bad_count = bad_count + 1;
            end
        end
    endtask
    // Bus write: address and data offered together, released once taken
    task axw(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= {16'h0000, d};
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            do begin
                @(posedge clk);
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
            end while (!s_axi_bvalid);
            resp = s_axi_bresp;
        end
    endtask
    // Bus read
    task axr(input [3:0] a);
        begin
            @(posedge clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            do begin
                @(posedge clk);
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
            end while (!s_axi_rvalid);
            data = s_axi_rdata;
            resp = s_axi_rresp;
        end
    endtask
    task give_verdict;
        begin
            $display("Checks %0d, mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // Watchdog at 4000 cycles, far beyond the hundred or so cycles the tests need
    initial begin
        #200000;
        bad_count = bad_count + 1;
        give_verdict;
    end
    // Main sequence
    initial begin
        cfg[0] = 16'h07E8; cfg[1] = 16'h0080; cfg[2] = 16'h0500;
        cfg[3] = 16'h02A0; cfg[4] = 16'h0000;
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        axr(`PPC_OFS_CTRL);
        chk("ctrl rst", data, {16'h0000, `PPC_CTRL_RESET});
        axw(`PPC_OFS_CTRL, 16'hFFFF);
        chk("wr resp", resp, `PPC_RESP_OKAY);
        axr(`PPC_OFS_CTRL);
        chk("ctrl msk", data, {16'h0000, `PPC_CTRL_WMASK});
        axw(4'hC, 16'h0000); // Unmapped write must leave ctrl alone
        chk("wr dec", resp, `PPC_RESP_DECERR);
        axr(4'h8);
        chk("rd dec", resp, `PPC_RESP_DECERR);
        axr(`PPC_OFS_CTRL);
        chk("ctrl kep", data, {16'h0000, `PPC_CTRL_WMASK}); // Unmapped write dropped
        // Enables 10, 9, 8 drive their pins; reserved select code releases pin 1
        axr(`PPC_OFS_STATUS);
        chk("stat rd", data, 32'h0000_0038);
        axw(`PPC_OFS_STATUS, 16'h0000);
        chk("stat wr", resp, `PPC_RESP_OKAY);
        axr(`PPC_OFS_CTRL);
        chk("ctrl kp2", data, {16'h0000, `PPC_CTRL_WMASK}); // Status write dropped
        // Lane 0 only: low byte cleared, high byte kept
        s_axi_wstrb <= 4'h1;
        axw(`PPC_OFS_CTRL, 16'h0000);
        s_axi_wstrb <= 4'hF;
        axr(`PPC_OFS_CTRL);
        chk("lane0", data, 32'h0000_0700);
        for (i = 0; i < 5; i = i + 1) begin
            c = cfg[i];
            axw(`PPC_OFS_CTRL, c);
            for (j = 0; j < 4; j = j + 1) begin
                @(posedge clk);
                {byte_enable_req, write_strobe_req, read_strobe_req, chip_select1_req,
                    addr_latch_low_req, addr_latch_high_req} <= {6{j[0]}};
                addr_latch_used <= j[1];
                @(posedge clk);
                #1;
                r = j[0];
                u = j[1];
                cso = (c[7:6] == `PPC_CSF_CHIP_SEL);
                chk("pins", {byte_enable_pin, byte_enable_pin_oe, write_strobe_pin,
                    write_strobe_pin_oe, read_strobe_pin, read_strobe_pin_oe, chip_select1_pin,
                    chip_select1_pin_oe, addr_latch_low_strobe, addr_latch_high_strobe,
                    addr_latch_oe}, {c[10] & r, c[10], c[9] & r, c[9], c[8] & r, c[8],
                    cso & (r ^ ~c[3]), cso, u & (r ^ ~c[5]), u & (r ^ ~c[5]), u});
            end
        end
        // Two pulses per enabled config plus one when enabling while requested
        chk("strobes", strobe_count, 32'h5);
        give_verdict;
    end
endmodule
